// [hw/parallel_io_port.sv]
// What this block does
// - while an enabled peripheral actively drives a shared pin the port driver is off but the pin stays readable.
// - an enabled peripheral that is not driving a pin leaves that pin to the port latch and direction.
// - a direction bit of one makes the pin an input with driver off, zero makes it an output.
// - after reset every implemented direction bit is set so all pins are inputs.
// - writing the latch register updates the latch and reading it returns the latch, not the pins.
// - reading the pin level register returns the pins and writing it writes the latch.
// - bits absent on this variant are disabled and their latch, direction and pin level read zero.
// - pins shared only with input functions are plain port pins with no output multiplexing.
// - each shared pin has a data and an enable multiplexer that give the peripheral priority.
// - pins configured as analog inputs read zero in the pin level register.
// - unimplemented bits ignore writes and read zero.
//
// Purpose: two sixteen-bit port groups behind an Avalon-MM slave
// Assumes: single clock, synchronous active-low reset, 32-bit bus with byte enables
// Notes: each access answers with waitrequest low in the second cycle
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "parallel_io_map.svh"
module parallel_io_port
    import parallel_io_pkg::*;
#(
    parameter logic [15:0] IMPL_A = `IMPL_MASK_A,
    parameter logic [15:0] IMPL_B = `IMPL_MASK_B,
    parameter logic [15:0] DEDICATED_A = `DEDICATED_NONE,
    parameter logic [15:0] DEDICATED_B = `DEDICATED_NONE
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // avalon-mm slave
    input wire logic [`ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // peripheral side, group a
    input wire logic [15:0] i_periph_enable_a,
    input wire logic [15:0] i_periph_drive_a,
    input wire logic [15:0] i_periph_out_a,
    // peripheral side, group b
    input wire logic [15:0] i_periph_enable_b,
    input wire logic [15:0] i_periph_drive_b,
    input wire logic [15:0] i_periph_out_b,
    // pads, group a
    input wire logic [15:0] i_pad_in_a,
    output logic [15:0] o_pad_out_a,
    output logic [15:0] o_pad_oe_a,
    // pads, group b
    input wire logic [15:0] i_pad_in_b,
    output logic [15:0] o_pad_out_b,
    output logic [15:0] o_pad_oe_b,
    // synchronised pin levels for on-chip input functions
    output logic [15:0] o_pin_level_a,
    output logic [15:0] o_pin_level_b
);

    ////////////////////////////////////////////////////////////////////////////////
    // decoding

    function automatic logic idx_hit(input logic [`ADDR_W-1:0] addr,
                                     input logic [`IDX_W-1:0] idx);
        idx_hit = (addr == {idx, 2'b00});
    endfunction

    function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (idx_hit(addr, `IDX_DIR_A))
            sel = SEL_DIR_A;
        else if (idx_hit(addr, `IDX_PIN_A))
            sel = SEL_PIN_A;
        else if (idx_hit(addr, `IDX_LAT_A))
            sel = SEL_LAT_A;
        else if (idx_hit(addr, `IDX_DIR_B))
            sel = SEL_DIR_B;
        else if (idx_hit(addr, `IDX_PIN_B))
            sel = SEL_PIN_B;
        else if (idx_hit(addr, `IDX_LAT_B))
            sel = SEL_LAT_B;
        else if (idx_hit(addr, `IDX_ANALOG_B))
            sel = SEL_ANALOG_B;
        decode = sel;
    endfunction

    // byte-lane merge restricted to implemented bits
    function automatic logic [15:0] merge(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [1:0] be,
                                          input logic [15:0] impl);
        logic [15:0] lane;
        lane = {{8{be[1]}}, {8{be[0]}}} & impl;
        merge = (old_val & ~lane) | (new_val & lane);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [15:0] dir_group_a_reg;
    logic [15:0] dir_group_b_reg;
    logic [15:0] out_latch_group_a_reg;
    logic [15:0] out_latch_group_b_reg;
    logic [15:0] analog_pin_config_reg;
    logic [15:0] level_a;
    logic [15:0] level_b;
    logic [15:0] pin_view_a;
    logic [15:0] pin_view_b;
    logic [15:0] owned_a;
    logic [15:0] owned_b;
    logic [15:0] rdata_next;
    logic req;
    logic accept;
    logic do_write;
    reg_sel_t sel;

    assign req = i_avs_read | i_avs_write;
    // the request is taken in the cycle waitrequest is low
    assign accept = req & ~o_avs_waitrequest;
    assign do_write = accept & i_avs_write;
    assign sel = decode(i_avs_address);

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle gives the read mux a full period

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // direction registers

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            dir_group_a_reg <= `DIR_A_RESET & IMPL_A;
            dir_group_b_reg <= `DIR_B_RESET & IMPL_B;
        end
        else if (do_write)
        begin
            if (sel == SEL_DIR_A)
                dir_group_a_reg <= merge(dir_group_a_reg, i_avs_writedata[15:0],
                                         i_avs_byteenable[1:0], IMPL_A);
            if (sel == SEL_DIR_B)
                dir_group_b_reg <= merge(dir_group_b_reg, i_avs_writedata[15:0],
                                         i_avs_byteenable[1:0], IMPL_B);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output latches: pin level writes land here too

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            out_latch_group_a_reg <= `LAT_RESET;
            out_latch_group_b_reg <= `LAT_RESET;
        end
        else if (do_write)
        begin
            if (sel == SEL_LAT_A || sel == SEL_PIN_A)
                out_latch_group_a_reg <= merge(out_latch_group_a_reg, i_avs_writedata[15:0],
                                               i_avs_byteenable[1:0], IMPL_A);
            if (sel == SEL_LAT_B || sel == SEL_PIN_B)
                out_latch_group_b_reg <= merge(out_latch_group_b_reg, i_avs_writedata[15:0],
                                               i_avs_byteenable[1:0], IMPL_B);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog configuration of group b

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            analog_pin_config_reg <= `ANALOG_RESET;
        else if (do_write && sel == SEL_ANALOG_B)
            analog_pin_config_reg <= merge(analog_pin_config_reg, i_avs_writedata[15:0],
                                           i_avs_byteenable[1:0], IMPL_B);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pad inputs

    pin_sync #(.W(16)) u_sync_a
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_pad(i_pad_in_a),
        .o_level(level_a)
    );

    pin_sync #(.W(16)) u_sync_b
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_pad(i_pad_in_b),
        .o_level(level_b)
    );

    // analog pins read low; the converter still sees the raw pad
    assign pin_view_a = level_a & IMPL_A;
    assign pin_view_b = level_b & IMPL_B & ~analog_pin_config_reg;

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            o_pin_level_a <= '0;
            o_pin_level_b <= '0;
        end
        else
        begin
            o_pin_level_a <= pin_view_a;
            o_pin_level_b <= pin_view_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb
    begin
        rdata_next = 16'h0000;
        unique case (sel)
            SEL_DIR_A: rdata_next = dir_group_a_reg;
            SEL_PIN_A: rdata_next = pin_view_a;
            SEL_LAT_A: rdata_next = out_latch_group_a_reg;
            SEL_DIR_B: rdata_next = dir_group_b_reg;
            SEL_PIN_B: rdata_next = pin_view_b;
            SEL_LAT_B: rdata_next = out_latch_group_b_reg;
            SEL_ANALOG_B: rdata_next = analog_pin_config_reg;
            SEL_NONE: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read && o_avs_waitrequest)
            o_avs_readdata <= {16'h0000, rdata_next};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pad ownership and output multiplexers

    // input-only sharers never take the pad
    assign owned_a = i_periph_enable_a & i_periph_drive_a & ~DEDICATED_A & IMPL_A;
    assign owned_b = i_periph_enable_b & i_periph_drive_b & ~DEDICATED_B & IMPL_B;

    pad_group_if #(.W(16)) grp_a ();
    pad_group_if #(.W(16)) grp_b ();

    assign grp_a.latch = out_latch_group_a_reg;
    assign grp_a.dir = dir_group_a_reg;
    assign grp_a.owned = owned_a;
    assign grp_a.impl = IMPL_A;
    assign grp_a.periph_out = i_periph_out_a;
    assign grp_b.latch = out_latch_group_b_reg;
    assign grp_b.dir = dir_group_b_reg;
    assign grp_b.owned = owned_b;
    assign grp_b.impl = IMPL_B;
    assign grp_b.periph_out = i_periph_out_b;

    pad_mux #(.W(16)) u_mux_a
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .grp(grp_a)
    );

    pad_mux #(.W(16)) u_mux_b
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .grp(grp_b)
    );

    assign o_pad_out_a = grp_a.pad_out;
    assign o_pad_oe_a = grp_a.pad_oe;
    assign o_pad_out_b = grp_b.pad_out;
    assign o_pad_oe_b = grp_b.pad_oe;

endmodule
`default_nettype wire

// [include/parallel_io_map.svh]
// Purpose: register indices, reset values and bit masks of the parallel io port
// Assumes: register byte address is four times the index
// Notes: definitions only
`ifndef PARALLEL_IO_MAP_SVH
`define PARALLEL_IO_MAP_SVH

`define ADDR_W 12
`define DATA_W 16
`define IDX_W 10

`define IDX_DIR_A 10'h2C0
`define IDX_PIN_A 10'h2C2
`define IDX_LAT_A 10'h2C4
`define IDX_DIR_B 10'h2C6
`define IDX_PIN_B 10'h2C8
`define IDX_LAT_B 10'h2CB
`define IDX_ANALOG_B 10'h2F0

`define IMPL_MASK_A 16'hF6C0
`define IMPL_MASK_B 16'hFFFF
`define DIR_A_RESET 16'hF6C0
`define DIR_B_RESET 16'hFFFF
`define LAT_RESET 16'h0000
`define ANALOG_RESET 16'h0000
`define DEDICATED_NONE 16'h0000

`endif

// [include/parallel_io_pkg.sv]
// Purpose: types shared by the parallel io port modules
// Assumes: nothing
// Notes: constants live in parallel_io_map.svh
package parallel_io_pkg;
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DIR_A,
        SEL_PIN_A,
        SEL_LAT_A,
        SEL_DIR_B,
        SEL_PIN_B,
        SEL_LAT_B,
        SEL_ANALOG_B
    } reg_sel_t;
endpackage

// [include/pad_group_if.sv]
// Purpose: carrier between the register logic and one group's pad multiplexer
// Assumes: one clock
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface pad_group_if #(parameter int W = 16);
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] owned;
    logic [W-1:0] impl;
    logic [W-1:0] periph_out;
    logic [W-1:0] pad_out;
    logic [W-1:0] pad_oe;
    modport ctrl (output latch, output dir, output owned, output impl, output periph_out,
                  input pad_out, input pad_oe);
    modport mux (input latch, input dir, input owned, input impl, input periph_out,
                 output pad_out, output pad_oe);
endinterface
`default_nettype wire

// [hw/pin_sync.sv]
// Purpose: two-flop synchroniser for a group of pad inputs
// Assumes: pads are asynchronous to i_clock
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(parameter int W = 16)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // pads
    input wire logic [W-1:0] i_pad,
    // synchronised level
    output logic [W-1:0] o_level
);
    logic [W-1:0] stage1_reg;

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            stage1_reg <= '0;
            o_level <= '0;
        end
        else
        begin
            stage1_reg <= i_pad;
            o_level <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// [hw/pad_mux.sv]
// Purpose: per-pin output data and enable selection between peripheral and port
// Assumes: owned already folds in peripheral enable, active drive and dedicated pins
// Notes: outputs are registered, one cycle behind their causes
`timescale 1ns/1ns
`default_nettype none
module pad_mux #(parameter int W = 16)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // group signals
    pad_group_if.mux grp
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_pin
            always_ff @(posedge i_clock)
            begin
                if (!i_reset_n)
                begin
                    grp.pad_out[i] <= 1'b0;
                    grp.pad_oe[i] <= 1'b0;
                end
                else if (!grp.impl[i])
                begin
                    // absent pins never drive
                    grp.pad_out[i] <= 1'b0;
                    grp.pad_oe[i] <= 1'b0;
                end
                else if (grp.owned[i])
                begin
                    // peripheral wins both multiplexers
                    grp.pad_out[i] <= grp.periph_out[i];
                    grp.pad_oe[i] <= 1'b1;
                end
                else
                begin
                    grp.pad_out[i] <= grp.latch[i];
                    grp.pad_oe[i] <= ~grp.dir[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [testbench/parallel_io_port_properties.sv]
// Purpose: port-level properties of the parallel io port
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module parallel_io_port_checker
#(
    parameter logic [15:0] IMPL_A = 16'hF6C0,
    parameter logic [15:0] IMPL_B = 16'hFFFF,
    parameter logic [15:0] DEDICATED_A = 16'h0000,
    parameter logic [15:0] DEDICATED_B = 16'h0000
)
(
    // clock, reset and bus
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // peripheral and pads
    input wire logic [15:0] i_periph_enable_a,
    input wire logic [15:0] i_periph_drive_a,
    input wire logic [15:0] i_periph_out_a,
    input wire logic [15:0] i_periph_enable_b,
    input wire logic [15:0] i_periph_drive_b,
    input wire logic [15:0] i_pad_in_a,
    input wire logic [15:0] o_pad_out_a,
    input wire logic [15:0] o_pad_oe_a,
    input wire logic [15:0] o_pad_oe_b,
    input wire logic [15:0] o_pin_level_a
);
    logic [15:0] own_a;
    logic [15:0] own_b;
    logic mapped;
    assign own_a = i_periph_enable_a & i_periph_drive_a & IMPL_A & ~DEDICATED_A;
    assign own_b = i_periph_enable_b & i_periph_drive_b & IMPL_B & ~DEDICATED_B;
    assign mapped = i_avs_address inside {12'hB00, 12'hB08, 12'hB10, 12'hB18, 12'hB20, 12'hB2C, 12'hBC0};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
    wait_answer_a: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
        else $error("bus answer late");
    unmapped_zero_a: assert property (!o_avs_waitrequest && i_avs_read && !mapped |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    owned_oe_a: assert property (1 |=> (o_pad_oe_a & $past(own_a)) == $past(own_a))
        else $error("peripheral pin a not enabled");
    owned_data_a: assert property (1 |=> ((o_pad_out_a ^ $past(i_periph_out_a)) & $past(own_a)) == 16'h0)
        else $error("peripheral data a not passed");
    owned_oe_b: assert property (1 |=> (o_pad_oe_b & $past(own_b)) == $past(own_b))
        else $error("peripheral pin b not enabled");
    impl_quiet_a: assert property (((o_pad_oe_a | o_pin_level_a) & ~IMPL_A) == 16'h0)
        else $error("absent bit active");
    pin_sync_a: assert property ($past(i_reset_n, 3) |-> o_pin_level_a == ($past(i_pad_in_a, 3) & IMPL_A))
        else $error("pin level not synchronised");
    reset_idle_a: assert property ($rose(i_reset_n) |-> o_avs_waitrequest && o_pad_oe_a == 16'h0)
        else $error("outputs busy after reset");
endmodule
bind parallel_io_port parallel_io_port_checker #(.IMPL_A(IMPL_A), .IMPL_B(IMPL_B), .DEDICATED_A(DEDICATED_A),
    .DEDICATED_B(DEDICATED_B)) checker_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_periph_enable_a(i_periph_enable_a), .i_periph_drive_a(i_periph_drive_a), .i_periph_out_a(i_periph_out_a),
    .i_periph_enable_b(i_periph_enable_b), .i_periph_drive_b(i_periph_drive_b), .i_pad_in_a(i_pad_in_a),
    .o_pad_out_a(o_pad_out_a), .o_pad_oe_a(o_pad_oe_a), .o_pad_oe_b(o_pad_oe_b), .o_pin_level_a(o_pin_level_a));
`default_nettype wire

// [testbench/pad_model.sv]
// Purpose: pad cells seen from outside the port
// Assumes: no pull resistors
// Notes: a driven pad loops the port's output back
`timescale 1ns/1ns
`default_nettype none
module pad_model
(
    // port side
    input wire logic [15:0] i_out,
    input wire logic [15:0] i_oe,
    // outside world
    input wire logic [15:0] i_ext,
    output logic [15:0] o_pad
);
    // an undriven pad shows whatever the board puts on it
    assign o_pad = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule
`default_nettype wire

// [testbench/parallel_io_port_test.sv]
// Purpose: self-checking bench of the parallel io port
// Assumes: one answer cycle per bus access
// Notes: pin 6 of group a is taken as input-only shared
`timescale 1ns/1ns
`default_nettype none
module parallel_io_port_test;
    localparam logic [11:0] DA = 12'hB00, PA = 12'hB08, LA = 12'hB10, DB = 12'hB18, PB = 12'hB20, LB = 12'hB2C;
    localparam logic [11:0] AN = 12'hBC0;
    logic clock = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, waitreq;
    logic [11:0] address = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] be = 4'h0;
    logic [15:0] en_a = 16'h0, drv_a = 16'h0, pout_a = 16'h0, en_b = 16'h0, drv_b = 16'h0, pout_b = 16'h0;
    logic [15:0] ext_a = 16'h0, ext_b = 16'h0, pin_a, pin_b, out_a, out_b, oe_a, oe_b, lvl_b;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    always #5 clock = ~clock;
    parallel_io_port #(.DEDICATED_A(16'h0040)) parallel_io_port_inst (.i_clock(clock), .i_reset_n(reset_n),
        .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_periph_enable_a(en_a), .i_periph_drive_a(drv_a), .i_periph_out_a(pout_a),
        .i_periph_enable_b(en_b), .i_periph_drive_b(drv_b), .i_periph_out_b(pout_b),
        .i_pad_in_a(pin_a), .o_pad_out_a(out_a), .o_pad_oe_a(oe_a), .i_pad_in_b(pin_b), .o_pad_out_b(out_b),
        .o_pad_oe_b(oe_b), .o_pin_level_a(), .o_pin_level_b(lvl_b));
    pad_model pad_a_inst (.i_out(out_a), .i_oe(oe_a), .i_ext(ext_a), .o_pad(pin_a));
    pad_model pad_b_inst (.i_out(out_b), .i_oe(oe_b), .i_ext(ext_b), .o_pad(pin_b));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        // far above the roughly 150 cycles the tests need
        if (cycles == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        @(posedge clock);
        address <= a;
        rd <= !w;
        wr <= w;
        wdata <= {16'h0000, d};
        be <= b;
        // design updates with non-blocking assignments, so this sees the sampled value
        do @(posedge clock); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h3, q);
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, 4'hF, q);
        check(what, q, exp);
    endtask
    task automatic settle();
        repeat (4) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk("dir_a", DA, 32'h0000F6C0);
        rchk("dir_b", DB, 32'h0000FFFF);
        rchk("lat_a", LA, 32'h0);
        rchk("lat_b", LB, 32'h0);
        rchk("analog", AN, 32'h0);
        check("oe_a", oe_a, 16'h0);
        $display("test reset done");
    endtask
    task automatic t_latch();
        logic [31:0] q;
        wreg(LA, 16'hFFFF);
        rchk("lat_a mask", LA, 32'h0000F6C0);
        wreg(PA, 16'h5AC3);
        rchk("lat_a via pin", LA, 32'h000052C0);
        rchk("pin_a input", PA, 32'h0);
        bus(1'b1, LB, 16'hABCD, 4'h1, q);
        rchk("lat_b byte", LB, 32'h000000CD);
        wreg(PB, 16'h1234);
        rchk("lat_b via pin", LB, 32'h00001234);
        wreg(12'hB04, 16'hFFFF);
        rchk("unmapped", 12'hB04, 32'h0);
        rchk("dir_a kept", DA, 32'h0000F6C0);
        $display("test latch done");
    endtask
    task automatic t_dir();
        wreg(DA, 16'h0000);
        settle();
        check("oe_a out", oe_a, 16'hF6C0);
        check("out_a", out_a, 16'h52C0);
        rchk("pin_a loop", PA, 32'h000052C0);
        rchk("dir_a zero", DA, 32'h0);
        wreg(DA, 16'hFFFF);
        settle();
        check("oe_a in", oe_a, 16'h0);
        rchk("dir_a set", DA, 32'h0000F6C0);
        $display("test direction done");
    endtask
    task automatic t_periph();
        wreg(DB, 16'h0000);
        wreg(LB, 16'h00FF);
        @(posedge clock);
        en_b <= 16'hFFFF;
        drv_b <= 16'h0F0F;
        pout_b <= 16'hAAAA;
        settle();
        check("oe_b", oe_b, 16'hFFFF);
        check("out_b", out_b, 16'h0AFA);
        rchk("pin_b", PB, 32'h00000AFA);
        wreg(DB, 16'hFFFF);
        ext_b <= 16'h5555;
        settle();
        check("oe_b in", oe_b, 16'h0F0F);
        rchk("pin_b mix", PB, 32'h00005A5A);
        en_b <= 16'h0;
        drv_b <= 16'h0;
        $display("test peripheral done");
    endtask
    task automatic t_dedicated();
        wreg(LA, 16'h0000);
        wreg(DA, 16'h0000);
        @(posedge clock);
        en_a <= 16'hFFFF;
        drv_a <= 16'hFFFF;
        pout_a <= 16'hFFFF;
        settle();
        check("oe_a ded", oe_a, 16'hF6C0);
        check("out_a ded", out_a, 16'hF680);
        en_a <= 16'h0;
        drv_a <= 16'h0;
        $display("test dedicated done");
    endtask
    task automatic t_analog();
        ext_b <= 16'hFFFF;
        wreg(DB, 16'hFFFF);
        wreg(AN, 16'h00F0);
        settle();
        rchk("analog", AN, 32'h000000F0);
        rchk("pin_b analog", PB, 32'h0000FF0F);
        check("level_b analog", lvl_b, 16'hFF0F);
        wreg(AN, 16'h0000);
        rchk("pin_b digital", PB, 32'h0000FFFF);
        check("level_b digital", lvl_b, 16'hFFFF);
        $display("test analog done");
    endtask
    task automatic t_rereset();
        wreg(LA, 16'hFFFF);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rchk("dir_a again", DA, 32'h0000F6C0);
        rchk("lat_a again", LA, 32'h0);
        $display("test second reset done");
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_latch();
        t_dir();
        t_periph();
        t_dedicated();
        t_analog();
        t_rereset();
        stop_test();
    end
endmodule
`default_nettype wire
